// ===== hw/bbls_cfg.svh
/*
 * constants of the backplane byte-lane master: clock rate, bus timer,
 * address layout and the idle levels of the active-low lines.
 * assumes it is included by its bare name wherever a figure is needed.
 */
`ifndef BBLS_CFG_SVH
`define BBLS_CFG_SVH

// clock period in ns (125 MHz)
`define BBLS_CLK_NS 8
// bus timer: longest wait for an answer before the cycle is ended, in ns
`define BBLS_TIMEOUT_NS 64000

// address layout: bit 1 picks the half, bits 31..2 pick the 4-byte group
`define BBLS_A01_BIT 1
`define BBLS_GRP_LSB 2
`define BBLS_ADDR_MSB 31
`define BBLS_LO_MSB 1

// negated level of an active-low line and its asserted level
`define BBLS_NEG 1'h1
`define BBLS_ASRT 1'h0

`endif

// ===== hw/bbls_lane_enc.sv
/*
 * byte-lane encoder: turns the two low address bits and a transfer size
 * into the levels of the two data strobes, address bit one and the
 * long-word line, all in asserted-high form. combinational.
 * assumes the caller inverts the strobes and long-word line for the pins.
 */
`timescale 1ns/1ns

module bbls_lane_enc (
   // request
   input wire logic [1:0] lo_i,
   input wire logic [1:0] size_i,
   // encoded lanes, 1 = asserted (line low) for strobes and long word
   output logic sel1_o,
   output logic sel0_o,
   output logic a01_o,
   output logic lword_o,
   output logic legal_o
);

   ////////////////////////////////////////////////////////////////////
   // table lookup; misaligned requests come out illegal with no strobe,
   // so the illegal long-word/one-strobe mixes can never be produced
   always_comb begin
      {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h00;
      unique case ({size_i, lo_i})
         {bbls_pkg::SZ_1, 2'h0}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h11; // byte 0
         {bbls_pkg::SZ_1, 2'h1}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h09; // byte 1
         {bbls_pkg::SZ_1, 2'h2}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h15; // byte 2
         {bbls_pkg::SZ_1, 2'h3}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h0d; // byte 3
         {bbls_pkg::SZ_2, 2'h0}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h19; // bytes 0-1
         {bbls_pkg::SZ_2, 2'h1}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h1f; // bytes 1-2
         {bbls_pkg::SZ_2, 2'h2}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h1d; // bytes 2-3
         {bbls_pkg::SZ_3, 2'h0}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h13; // bytes 0-2
         {bbls_pkg::SZ_3, 2'h1}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h0b; // bytes 1-3
         {bbls_pkg::SZ_4, 2'h0}: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h1b; // bytes 0-3
         default: {sel1_o, sel0_o, a01_o, lword_o, legal_o} = 5'h00;
      endcase
   end

endmodule : bbls_lane_enc

// ===== hw/bbls_master.sv
/*
 * backplane byte-lane master: takes a byte address, size and direction
 * from local logic, runs one interlocked data transfer cycle on the
 * asynchronous backplane and reports done, bus error, timeout or reject.
 * assumes bus ownership is already held, and that the response lines are
 * already synchronous to clk_sys_i; pin wiring is done by the enables.
 */
// Contract
// - starred lines mean asserted or valid while low
// - starred edge lines act on their high to low fall
// - interlocked signals stay asserted until acknowledged, with no time limit
// - master waits for slave answer; a bus timer ends unanswered cycles
// - master picks the 4-byte group with address lines two to thirty-one
// - two strobes, address bit one and long word pick 1 to 4 bytes
// - never end a cycle with long word low, bit one high, one strobe
// - middle-two-byte cycles may pass briefly through an illegal mix
// - long word low with bit one high means both strobes low
// - strobe levels pick bytes; strobe edges time the data handoff
// - free-running clock lines have no fixed phase to other timing
// - byte 0 is upper strobe low, lower high, bit one low, long high
`timescale 1ns/1ns
`include "bbls_cfg.svh"

module bbls_master #(
   parameter int TIMEOUT_CYC = (`BBLS_TIMEOUT_NS + `BBLS_CLK_NS - 1) / `BBLS_CLK_NS
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // local request
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic [1:0] size_i,
   input wire logic write_i,
   input wire logic [31:0] wdata_i,
   // local answer
   output logic ready_o,
   output logic done_o,
   output logic berr_o,
   output logic tmo_o,
   output logic rej_o,
   output logic [31:0] rdata_o,
   // backplane address and select lines
   output logic [30:0] a_o,
   output logic lword_n_o,
   output logic as_n_o,
   output logic ds0_n_o,
   output logic ds1_n_o,
   output logic write_n_o,
   output logic ctl_oe_o,
   // backplane data lines
   input wire logic [31:0] d_i,
   output logic [31:0] d_o,
   output logic d_oe_o,
   // backplane responses
   input wire logic dtack_n_i,
   input wire logic berr_n_i
);

   localparam int CW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(TIMEOUT_CYC - 1);

   bbls_pkg::bbls_state_t state, next_state;
   logic [CW-1:0] cnt, next_cnt;
   logic [29:0] grp, next_grp;
   logic sel1, next_sel1, sel0, next_sel0;
   logic a01, next_a01, lword, next_lword;
   logic wr, next_wr;
   logic [31:0] wdata, next_wdata;
   logic [31:0] rdata, next_rdata;
   logic as_n, next_as_n, ds0_n, next_ds0_n, ds1_n, next_ds1_n;
   logic ctl_oe, next_ctl_oe, d_oe, next_d_oe;
   logic done, next_done, berr, next_berr, tmo, next_tmo, rej, next_rej;
   logic enc_sel1, enc_sel0, enc_a01, enc_lword, enc_legal;

   ////////////////////////////////////////////////////////////////////
   // lane encoding of the incoming request
   bbls_lane_enc u_enc (
      .lo_i(addr_i[`BBLS_LO_MSB:0]),
      .size_i(size_i),
      .sel1_o(enc_sel1),
      .sel0_o(enc_sel0),
      .a01_o(enc_a01),
      .lword_o(enc_lword),
      .legal_o(enc_legal)
   );

   // true when a response line is seen asserted (low level); the pin logic
   // hands the answers over already synchronised, so they are decoded straight
   function automatic logic seen_low(input logic line_n);
      seen_low = (line_n == `BBLS_ASRT);
   endfunction : seen_low

   ////////////////////////////////////////////////////////////////////
   // next-state logic of the cycle controller
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_grp = grp;
      next_sel1 = sel1;
      next_sel0 = sel0;
      next_a01 = a01;
      next_lword = lword;
      next_wr = wr;
      next_wdata = wdata;
      next_rdata = rdata;
      next_as_n = as_n;
      next_ds0_n = ds0_n;
      next_ds1_n = ds1_n;
      next_ctl_oe = ctl_oe;
      next_d_oe = d_oe;
      next_done = 1'h0;
      next_berr = 1'h0;
      next_tmo = 1'h0;
      next_rej = 1'h0;
      unique case (state)
         bbls_pkg::ST_IDLE: begin
            if (req_i) begin
               if (enc_legal) begin
                  // drive the group and selects one cycle before the strobes
                  next_grp = addr_i[`BBLS_ADDR_MSB:`BBLS_GRP_LSB];
                  next_sel1 = enc_sel1;
                  next_sel0 = enc_sel0;
                  next_a01 = enc_a01;
                  next_lword = enc_lword;
                  next_wr = write_i;
                  next_wdata = wdata_i;
                  next_ctl_oe = 1'h1;
                  next_d_oe = write_i;
                  next_state = bbls_pkg::ST_SETUP;
               end else begin
                  next_rej = 1'h1; // misaligned size never reaches the bus
               end
            end
         end
         bbls_pkg::ST_SETUP: begin
            // both strobes fall on the same edge, so no transient mix shows
            // the first low levels are already the final ones a slave decodes
            // and a slave may skip telling middle pairs from illegal mixes
            next_as_n = `BBLS_ASRT;
            next_ds1_n = ~sel1;
            next_ds0_n = ~sel0;
            next_cnt = '0;
            next_state = bbls_pkg::ST_STRB;
         end
         bbls_pkg::ST_STRB: begin
            next_cnt = cnt + CW'(1);
            // strobes held until an answer arrives or the timer ends it
            if (seen_low(dtack_n_i) || seen_low(berr_n_i) || cnt == CNT_LAST) begin
               if (seen_low(dtack_n_i)) begin
                  next_done = 1'h1; // local signal that the selected bytes were accessed
                  if (!wr) begin
                     next_rdata = d_i; // data taken at the acknowledge
                  end
               end else if (seen_low(berr_n_i)) begin
                  next_berr = 1'h1;
               end else begin
                  next_tmo = 1'h1; // bus timer
               end
               next_as_n = `BBLS_NEG;
               next_ds0_n = `BBLS_NEG; // strobe rise ends the handoff
               next_ds1_n = `BBLS_NEG;
               next_d_oe = 1'h0;
               next_state = bbls_pkg::ST_RELS;
            end
         end
         bbls_pkg::ST_RELS: begin
            // the slave must drop its answer before a new cycle may start
            if (!seen_low(dtack_n_i) && !seen_low(berr_n_i)) begin
               next_ctl_oe = 1'h0;
               next_state = bbls_pkg::ST_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // registers of the cycle controller; every step keys off clk_sys_i and the
   // strobe handshake, no backplane clock line is read or assumed in phase
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state <= bbls_pkg::ST_IDLE;
         cnt <= '0;
         grp <= '0;
         sel1 <= 1'h0;
         sel0 <= 1'h0;
         a01 <= 1'h0;
         lword <= 1'h0;
         wr <= 1'h0;
         wdata <= '0;
         rdata <= '0;
         as_n <= `BBLS_NEG;
         ds0_n <= `BBLS_NEG;
         ds1_n <= `BBLS_NEG;
         ctl_oe <= 1'h0;
         d_oe <= 1'h0;
         done <= 1'h0;
         berr <= 1'h0;
         tmo <= 1'h0;
         rej <= 1'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         grp <= next_grp;
         sel1 <= next_sel1;
         sel0 <= next_sel0;
         a01 <= next_a01;
         lword <= next_lword;
         wr <= next_wr;
         wdata <= next_wdata;
         rdata <= next_rdata;
         as_n <= next_as_n;
         ds0_n <= next_ds0_n;
         ds1_n <= next_ds1_n;
         ctl_oe <= next_ctl_oe;
         d_oe <= next_d_oe;
         done <= next_done;
         berr <= next_berr;
         tmo <= next_tmo;
         rej <= next_rej;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pins: all from flip-flops except the ready handshake
   assign ready_o = (state == bbls_pkg::ST_IDLE);
   // result pulses go out to local logic unacknowledged, each held one full cycle
   assign done_o = done;
   assign berr_o = berr;
   assign tmo_o = tmo;
   assign rej_o = rej;
   assign rdata_o = rdata;
   assign a_o = {grp, a01};
   assign lword_n_o = ~lword;
   assign as_n_o = as_n;
   assign ds0_n_o = ds0_n;
   assign ds1_n_o = ds1_n;
   assign write_n_o = ~wr;
   assign ctl_oe_o = ctl_oe;
   assign d_o = wdata;
   assign d_oe_o = d_oe;

   ////////////////////////////////////////////////////////////////////
   // checks on the driven lines
   sequence s_setup;
      state == bbls_pkg::ST_SETUP && as_n_o && ds0_n_o && ds1_n_o;
   endsequence

   sequence s_strobe;
      !as_n_o && (!ds0_n_o || !ds1_n_o);
   endsequence

   a_launch_order: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ready_o && req_i && enc_legal) |=> s_setup ##1 s_strobe)
      else $error("strobes did not fall one cycle after address setup");

   a_no_illegal_mix: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !(!lword_n_o && a_o[0] && (ds0_n_o != ds1_n_o)))
      else $error("illegal long word, bit one and single strobe mix driven");

   a_both_strobes: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!as_n_o && !lword_n_o && a_o[0]) |-> (!ds0_n_o && !ds1_n_o))
      else $error("long word low with bit one high lacks both strobes");

   a_hold_strobes: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!as_n_o && dtack_n_i && berr_n_i && cnt != CNT_LAST)
         |=> (!as_n_o && $stable(ds0_n_o) && $stable(ds1_n_o)))
      else $error("strobes removed before acknowledge");

   a_timer_ends: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == bbls_pkg::ST_STRB && cnt == CNT_LAST && dtack_n_i && berr_n_i)
         |=> (tmo_o && as_n_o && ds0_n_o && ds1_n_o))
      else $error("bus timer did not end an unanswered cycle");

   a_ack_capture: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!as_n_o && !dtack_n_i && !write_n_o == 1'h0 && state == bbls_pkg::ST_STRB)
         |=> (done_o && rdata_o == $past(d_i) && ds0_n_o && ds1_n_o))
      else $error("read data not taken at acknowledge");

   a_release_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state == bbls_pkg::ST_RELS && !dtack_n_i) |=> (!ready_o && as_n_o && ctl_oe_o))
      else $error("new cycle allowed while slave still answers");

   a_byte0_code: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ready_o && req_i && size_i == bbls_pkg::SZ_1 && addr_i[`BBLS_LO_MSB:0] == 2'h0)
         |=> ##1 (!ds1_n_o && ds0_n_o && !a_o[0] && lword_n_o))
      else $error("byte 0 cycle not encoded as upper strobe only");

   a_one_result: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (done_o || berr_o || tmo_o) |-> $onehot({done_o, berr_o, tmo_o}) ##1 !(done_o || berr_o || tmo_o))
      else $error("cycle result not a single one-cycle pulse");

   a_reject_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ready_o && req_i && !enc_legal) |=> (rej_o && ready_o && as_n_o && !ctl_oe_o))
      else $error("misaligned request reached the bus");

endmodule : bbls_master

// ===== hw/bbls_pkg.sv
/*
 * types of the backplane byte-lane master: controller states and
 * transfer sizes. assumes nothing of its surroundings.
 */
package bbls_pkg;

   // controller states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_SETUP = 4'h2,
      ST_STRB  = 4'h4,
      ST_RELS  = 4'h8
   } bbls_state_t;

   // number of bytes moved by one cycle
   typedef enum logic [1:0] {
      SZ_1 = 2'h0,
      SZ_2 = 2'h1,
      SZ_3 = 2'h2,
      SZ_4 = 2'h3
   } bbls_size_t;

endpackage : bbls_pkg

// ===== tb/bbls_slave_model.sv
/*
 * behavioural backplane slave facing the byte-lane master: decodes the
 * lanes, answers with acknowledge, bus error or silence after a delay.
 * assumes the master's lines are synchronous to clk_sys_i.
 */
`timescale 1ns/1ns

module bbls_slave_model (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // lines from the master
   input wire logic [30:0] a_i,
   input wire logic lword_n_i,
   input wire logic as_n_i,
   input wire logic ds0_n_i,
   input wire logic ds1_n_i,
   input wire logic write_n_i,
   input wire logic [31:0] d_o_i,
   // behaviour: 0 acknowledge, 1 bus error, 2 silent
   input wire logic [1:0] mode_i,
   input wire logic [7:0] dly_i,
   input wire logic [31:0] rd_word_i,
   // answers and what was seen
   output logic dtack_n_o,
   output logic berr_n_o,
   output logic [31:0] d_i_o,
   output logic [3:0] lanes_o,
   output logic [29:0] grp_o,
   output logic [31:0] wcap_o
);
   logic [7:0] cnt;
   logic [3:0] lanes;

   ////////////////////////////////////////////////////////////////////////
   // lane decode from the final levels; the two illegal mixes give none
   always_comb begin
      case ({ds1_n_i, ds0_n_i, a_i[0], lword_n_i})
         4'b0101: lanes = 4'h1;
         4'b0111: lanes = 4'h4;
         4'b0100: lanes = 4'h7;
         4'b1001: lanes = 4'h2;
         4'b1011: lanes = 4'h8;
         4'b1000: lanes = 4'he;
         4'b0001: lanes = 4'h3;
         4'b0011: lanes = 4'hc;
         4'b0000: lanes = 4'hf;
         4'b0010: lanes = 4'h6;
         default: lanes = 4'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // answer after dly_i settled cycles, hold it until the strobes rise
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         dtack_n_o <= 1'h1;
         berr_n_o <= 1'h1;
         cnt <= 8'h0;
         d_i_o <= 32'h5a5a5a5a;
         lanes_o <= 4'h0;
         grp_o <= 30'h0;
         wcap_o <= 32'h0;
      end else if (!as_n_i && !(ds0_n_i && ds1_n_i)) begin
         if (cnt == dly_i && mode_i != 2'h2) begin
            dtack_n_o <= (mode_i != 2'h0);
            berr_n_o <= (mode_i != 2'h1);
            lanes_o <= lanes;
            grp_o <= a_i[30:1];
            wcap_o <= write_n_i ? 32'h0 : d_o_i; // only a write direction hands data over
            d_i_o <= write_n_i ? rd_word_i : ~d_i_o;
         end else begin
            cnt <= cnt + 8'h1;
            d_i_o <= ~d_i_o;
         end
      end else begin
         // pulled-up answer lines go high; released data keeps toggling
         dtack_n_o <= 1'h1;
         berr_n_o <= 1'h1;
         cnt <= 8'h0;
         d_i_o <= ~d_i_o;
      end
   end
endmodule : bbls_slave_model

// ===== tb/test_backplane_byte_lane_select.sv
/*
 * self-checking bench of the byte-lane master with a slave model.
 * assumes a 125 MHz clock and a bus timer shortened to 16 cycles.
 */
`timescale 1ns/1ns

module test_backplane_byte_lane_select;
   typedef struct {logic [3:0] kind; logic wr; logic [31:0] data; logic [3:0] lanes; logic [29:0] grp;} bbls_exp_t;
   logic clk_sys_i = 1'h0, rst_i = 1'h1, req_i = 1'h0, write_i = 1'h0;
   logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o, d_i, d_o, rd_word = 32'h0, wcap;
   logic [1:0] size_i = 2'h0, mode = 2'h0;
   logic [7:0] dly = 8'h1;
   logic ready_o, done_o, berr_o, tmo_o, rej_o, lword_n_o, as_n_o, ds0_n_o, ds1_n_o, write_n_o;
   logic ctl_oe_o, d_oe_o, dtack_n, berr_n;
   logic [30:0] a_o;
   logic [3:0] lanes;
   logic [29:0] grp;
   int err_count = 0, checks = 0;
   bbls_exp_t exp_q[$];
   bbls_exp_t got_e;

   always #4 clk_sys_i = ~clk_sys_i;

   bbls_master #(.TIMEOUT_CYC(16)) bbls_master_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i),
      .addr_i(addr_i), .size_i(size_i), .write_i(write_i), .wdata_i(wdata_i), .ready_o(ready_o),
      .done_o(done_o), .berr_o(berr_o), .tmo_o(tmo_o), .rej_o(rej_o), .rdata_o(rdata_o), .a_o(a_o),
      .lword_n_o(lword_n_o), .as_n_o(as_n_o), .ds0_n_o(ds0_n_o), .ds1_n_o(ds1_n_o), .write_n_o(write_n_o),
      .ctl_oe_o(ctl_oe_o), .d_i(d_i), .d_o(d_o), .d_oe_o(d_oe_o), .dtack_n_i(dtack_n), .berr_n_i(berr_n));

   bbls_slave_model bbls_slave_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .a_i(a_o),
      .lword_n_i(lword_n_o), .as_n_i(as_n_o), .ds0_n_i(ds0_n_o), .ds1_n_i(ds1_n_o), .write_n_i(write_n_o),
      .d_o_i(d_o), .mode_i(mode), .dly_i(dly), .rd_word_i(rd_word), .dtack_n_o(dtack_n),
      .berr_n_o(berr_n), .d_i_o(d_i), .lanes_o(lanes), .grp_o(grp), .wcap_o(wcap));

   ////////////////////////////////////////////////////////////////////////
   // comparison and verdict
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////
   // one request: note the expected answer, pulse req_i, wait for idle
   task automatic run(input logic [31:0] addr, input logic [1:0] size, input logic wr, input logic [1:0] md,
                      input logic [7:0] dl);
      bbls_exp_t e;
      int n;
      e.data = $urandom;
      e.wr = wr;
      e.grp = addr[31:2];
      e.lanes = 4'(((8'h2 << size) - 8'h1) << addr[1:0]);
      e.kind = ({1'h0, addr[1:0]} + {1'h0, size} > 3'h3) ? 4'h1 : (4'h8 >> md);
      mode = md;
      dly = dl;
      rd_word = e.data;
      wdata_i = e.data;
      addr_i = addr;
      size_i = size;
      write_i = wr;
      exp_q.push_back(e);
      req_i = 1'h1;
      @(negedge clk_sys_i);
      req_i = 1'h0;
      repeat (2) @(negedge clk_sys_i);
      n = 0;
      while (ready_o !== 1'h1 && n < 200) begin
         @(negedge clk_sys_i);
         n++;
      end
      cmp("ready after cycle", 32'h1, {31'h0, ready_o});
   endtask : run

   ////////////////////////////////////////////////////////////////////////
   // watcher: pulses stand one cycle, so each negedge sees them once
   always @(negedge clk_sys_i) begin
      if (!rst_i && (done_o | berr_o | tmo_o | rej_o) === 1'h1) begin
         if (exp_q.size() == 0) begin
            cmp("unexpected answer", 32'h0, {28'h0, done_o, berr_o, tmo_o, rej_o});
         end else begin
            got_e = exp_q.pop_front();
            cmp("answer kind", 32'(got_e.kind), {28'h0, done_o, berr_o, tmo_o, rej_o});
            if (done_o === 1'h1) begin
               cmp("byte lanes", 32'(got_e.lanes), {28'h0, lanes});
               cmp("group", 32'(got_e.grp), {2'h0, grp});
               cmp("data", got_e.data, got_e.wr ? wcap : rdata_o);
            end
         end
      end
   end

   // a hang costs at most this many cycles
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_count++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(32'h6117));
      repeat (8) @(negedge clk_sys_i);
      rst_i = 1'h0;
      @(negedge clk_sys_i);
      cmp("idle lines", 32'h7c, {25'h0, as_n_o, ds0_n_o, ds1_n_o, lword_n_o, write_n_o, ctl_oe_o, d_oe_o});
      $display("test reset done");
      for (int k = 0; k < 16; k++) begin
         run({30'($urandom), 2'(k)}, 2'(k >> 2), k[0], 2'h0, 8'h1);
      end
      $display("test lane table done");
      run($urandom, 2'h0, 1'h0, 2'h1, 8'h2);
      run({30'($urandom), 2'h0}, 2'h3, 1'h1, 2'h2, 8'h0); // aligned, so the timer really runs
      $display("test error and timer done");
      fork
         run(32'h00001230, 2'h0, 1'h0, 2'h0, 8'hc);
         begin
            repeat (10) @(negedge clk_sys_i);
            cmp("held strobes", 32'h1, {28'h0, as_n_o, ds1_n_o, d_oe_o, ctl_oe_o});
         end
      join
      $display("test slow answer done");
      for (int k = 0; k < 40; k++) begin
         run($urandom, 2'($urandom), 1'($urandom), 2'($urandom % 2), 8'($urandom % 8));
      end
      $display("test random done");
      repeat (4) @(negedge clk_sys_i);
      cmp("queue drained", 32'h0, 32'(exp_q.size()));
      close_out();
   end
endmodule : test_backplane_byte_lane_select
